// ---- hdl/binary_delay_timer_pkg.sv ----
// constants for the programmable binary delay timer
package binary_delay_timer_pkg;
    localparam int TAP_COUNT = 8;
    localparam int SYNC_STAGES = 3;
    // base period of the time base, in ns (one rc constant stand-in)
    localparam int BASE_PERIOD_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BASE_PERIOD_CYC = (BASE_PERIOD_NS / CLK_PERIOD_NS < 2) ? 2 :
        BASE_PERIOD_NS / CLK_PERIOD_NS;
    // low part of each time-base pulse, in ns
    localparam int PULSE_LOW_NS = 500;
    localparam int PULSE_LOW_CYC = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] TAPS_IDLE = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
endpackage

// ---- hdl/binary_delay_timer.sv ----
// control flip-flop, time base and ripple-equivalent counter of the delay timer
// Behaviour
// - after power-up with no inputs, idle with every tap released high.
// - a rising trigger starts a timing cycle from idle.
// - starting enables time base and counter and pulls every tap low.
// - running time base emits one low pulse per base period on its output, from the second period on.
// - counter advances once per time-base pulse while running.
// - a rising reset ends the cycle and returns to idle.
// - further triggers are ignored while a cycle runs.
// - trigger and reset together: trigger wins, timing starts or continues.
// - in reset, time base and counter stop and every tap stays high.
// - taps fed back to reset end the cycle at the programmed count.
// - a lone tap stays low for its weight times the base period.
// - tied taps stay low for the summed weights times the base period.
// - with no feedback the counter cycles freely after a trigger.
// - counter steps on each falling time-base edge; output idles high.
// - taps are open-drain, so a shared bus is low if any tap is low.
`timescale 1ns/100ps
`default_nettype none
module binary_delay_timer #(
    parameter int BASE_PERIOD_CYC = binary_delay_timer_pkg::BASE_PERIOD_CYC,
    parameter int PULSE_LOW_CYC = binary_delay_timer_pkg::PULSE_LOW_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic trigger_in,
    input wire logic reset_pulse_in,
    output logic time_base_pulse_out,
    output logic [binary_delay_timer_pkg::TAP_COUNT-1:0] weighted_count_taps_out,
    output logic [binary_delay_timer_pkg::TAP_COUNT-1:0] weighted_count_taps_oe,
    output logic running
);
    localparam int N = binary_delay_timer_pkg::TAP_COUNT;
    localparam int SW = binary_delay_timer_pkg::SYNC_STAGES;
    localparam int CW = $clog2(BASE_PERIOD_CYC + 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a pin level is only believed once the two oldest stages agree
    function automatic logic agreed_level(input logic [SW-1:0] stages, input logic held);
        logic agree;
        agree = stages[SW-1] == stages[SW-2];
        return agree ? stages[SW-1] : held;
    endfunction

    function automatic logic rising(input logic now_level, input logic was_level);
        return now_level & ~was_level;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] trig_sync_q;
    logic [SW-1:0] rst_sync_q;
    logic trig_level_q;
    logic rst_level_q;
    wire trig_level_d = agreed_level(trig_sync_q, trig_level_q);
    wire rst_level_d = agreed_level(rst_sync_q, rst_level_q);
    // stage 0 only feeds stage 1; edges are taken on agreed levels
    wire trig_rise = rising(trig_level_d, trig_level_q);
    wire rst_rise = rising(rst_level_d, rst_level_q);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_sync_q <= '0;
        end else begin
            trig_sync_q <= {trig_sync_q[SW-2:0], trigger_in};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[SW-2:0], reset_pulse_in};
        end
    end

    // low after reset, matching the idle level of both pins, so no false edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_level_q <= 1'b0;
        end else begin
            trig_level_q <= trig_level_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_level_q <= 1'b0;
        end else begin
            rst_level_q <= rst_level_d;
        end
    end

    // ------------------------------------------------------------
    // control flip-flop
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        TIMING = 2'b10
    } ctrl_state_e;
    ctrl_state_e state_q;
    ctrl_state_e state_d;
    wire start = trig_rise & (state_q == IDLE);

    always_comb begin
        case (state_q)
            IDLE: state_d = trig_rise ? TIMING : IDLE;
            // a reset edge alongside a trigger edge keeps timing
            TIMING: state_d = (rst_rise && !trig_rise) ? IDLE : TIMING;
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    wire run_next = state_d == TIMING;
    wire restart = !run_next || start;

    // ------------------------------------------------------------
    // time base: period counter, low pulse at the head of each period after the first
    // ------------------------------------------------------------
    logic [CW-1:0] phase_q;
    logic armed_q;
    logic tb_q;
    wire phase_wrap = phase_q == CW'(BASE_PERIOD_CYC - 1);
    wire [CW-1:0] phase_step = phase_wrap ? '0 : phase_q + CW'(1);
    wire [CW-1:0] phase_d = restart ? '0 : phase_step;
    // no pulse heads the first period, so tap 0 stays low one full period
    wire armed_d = !restart && (armed_q || phase_wrap);
    wire in_low = phase_d < CW'(PULSE_LOW_CYC);
    wire tb_d = !(armed_d && in_low);
    wire tb_fall = tb_q & ~tb_d;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tb_q <= 1'b1;
        end else begin
            tb_q <= tb_d;
        end
    end

    // ------------------------------------------------------------
    // binary counter and taps; tap k is low while count bit k is 0
    // ------------------------------------------------------------
    logic [N-1:0] count_q;
    wire [N-1:0] count_step = tb_fall ? count_q + N'(1) : count_q;
    wire [N-1:0] count_d = restart ? binary_delay_timer_pkg::COUNT_RESET : count_step;
    // idle: all released; running: low where the count bit is clear
    wire [N-1:0] pull_d = run_next ? ~count_d : ~binary_delay_timer_pkg::TAPS_IDLE;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= binary_delay_timer_pkg::COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            weighted_count_taps_oe <= '0;
        end else begin
            weighted_count_taps_oe <= pull_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            time_base_pulse_out <= 1'b1;
        end else begin
            time_base_pulse_out <= tb_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            running <= 1'b0;
        end else begin
            running <= run_next;
        end
    end

    // open drain: only ever drives low, the pull-up gives the high level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            weighted_count_taps_out <= '0;
        end else begin
            weighted_count_taps_out <= '0;
        end
    end
endmodule
`default_nettype wire

// ---- sim/pulse_source.sv ----
// far-side source of reset pulses, with optional wired tap feedback
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
    input wire logic rst_cmd,
    input wire logic [7:0] fb_sel,
    input wire logic [7:0] weighted_count_taps_oe,
    output logic reset_pulse_in
);
    // pulled-up shared bus: low while any selected tap conducts
    assign reset_pulse_in = rst_cmd | (|fb_sel & ~|(fb_sel & weighted_count_taps_oe));
endmodule
`default_nettype wire

// ---- sim/binary_delay_timer_assertions.sv ----
// port checks for the delay timer
`timescale 1ns/100ps
`default_nettype none
module binary_delay_timer_assertions #(
    parameter int PERIOD = 4,
    parameter int PULSE_LOW = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic trigger_in,
    input wire logic reset_pulse_in,
    input wire logic time_base_pulse_out,
    input wire logic running,
    input wire logic [7:0] weighted_count_taps_out,
    input wire logic [7:0] weighted_count_taps_oe
);
    wire [7:0] oe = weighted_count_taps_oe;
    int low_cnt;
    // length of the current low stretch of the time base
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= time_base_pulse_out ? 0 : low_cnt + 1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_idle_taps_off: assert property (!running |-> oe == 8'h00) else $error("taps on idle");
    chk_idle_tb_high: assert property (!running |-> time_base_pulse_out) else $error("tb idle");
    chk_start_all_low: assert property ($rose(running) |-> oe == 8'hFF) else $error("start");
    chk_trig_starts: assert property ($rose(trigger_in) && !running |-> ##[1:5] running)
        else $error("no start");
    chk_reset_stops: assert property (running && $rose(reset_pulse_in) && $stable(trigger_in)
        |-> ##[1:5] !running) else $error("no stop");
    chk_count_step: assert property (running && $fell(time_base_pulse_out) |-> ##[0:2] $changed(oe))
        else $error("no count");
    chk_pulse_low: assert property ($rose(time_base_pulse_out) && running |-> low_cnt == PULSE_LOW)
        else $error("pulse width");
    chk_tb_period: assert property (running && $fell(time_base_pulse_out)
        |-> ##PERIOD ($fell(time_base_pulse_out) || !running)) else $error("period");
    chk_taps_low_only: assert property (weighted_count_taps_out == 8'h00)
        else $error("tap driven high");
    cov_start: cover property ($rose(running));
    cov_stop: cover property ($fell(running));
    cov_ignored: cover property (running && $rose(trigger_in));
endmodule
bind binary_delay_timer binary_delay_timer_assertions #(
    .PERIOD(BASE_PERIOD_CYC),
    .PULSE_LOW(PULSE_LOW_CYC)
) chk_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .trigger_in(trigger_in),
    .reset_pulse_in(reset_pulse_in),
    .time_base_pulse_out(time_base_pulse_out),
    .running(running),
    .weighted_count_taps_out(weighted_count_taps_out),
    .weighted_count_taps_oe(weighted_count_taps_oe)
);
`default_nettype wire

// ---- sim/test_binary_delay_timer.sv ----
// self-checking bench for the delay timer
`timescale 1ns/100ps
`default_nettype none
module test_binary_delay_timer;
    logic clk_sys = 1'b0, reset_n = 1'b0, trigger_in = 1'b0, rst_cmd = 1'b0, running;
    logic reset_pulse_in, time_base_pulse_out;
    logic [7:0] fb_sel = 8'h00, weighted_count_taps_out, weighted_count_taps_oe;
    int err_count = 0, num_checks = 0, n;
    localparam int PERIOD = 4;
    always #5 clk_sys = ~clk_sys;
    binary_delay_timer #(
        .BASE_PERIOD_CYC(PERIOD),
        .PULSE_LOW_CYC(2)
    ) dut_u (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .trigger_in(trigger_in),
        .reset_pulse_in(reset_pulse_in),
        .time_base_pulse_out(time_base_pulse_out),
        .weighted_count_taps_out(weighted_count_taps_out),
        .weighted_count_taps_oe(weighted_count_taps_oe),
        .running(running)
    );
    pulse_source src_u (
        .rst_cmd(rst_cmd),
        .fb_sel(fb_sel),
        .weighted_count_taps_oe(weighted_count_taps_oe),
        .reset_pulse_in(reset_pulse_in)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
        err_count += int'(seen !== exp);
    endtask
    task automatic print_verdict;
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // held five cycles so the effect has landed when the task returns
    task automatic pulse(input logic [9:0] v);
        repeat (3) @(posedge clk_sys);
        {trigger_in, rst_cmd, fb_sel} <= v;
        repeat (5) @(posedge clk_sys);
        {trigger_in, rst_cmd} <= 2'b00;
    endtask
    // outputs are looked at on the falling edge, where they are settled
    task automatic t_ctrl;
        int falls;
        logic tb_seen;
        @(negedge clk_sys);
        check(weighted_count_taps_oe, 8'h00);
        check(8'({running, time_base_pulse_out}), 8'h01);
        pulse(10'h300);
        @(negedge clk_sys);
        check(8'(running), 8'h01);
        check(weighted_count_taps_oe, 8'hFF);
        pulse(10'h200);
        @(negedge clk_sys);
        check(8'(weighted_count_taps_oe != 8'hFF), 8'h01);
        falls = 0;
        tb_seen = time_base_pulse_out;
        repeat (10 * PERIOD) begin
            @(negedge clk_sys);
            falls += int'(tb_seen && !time_base_pulse_out);
            tb_seen = time_base_pulse_out;
        end
        check(8'(falls), 8'h0A);
        repeat (1000) @(negedge clk_sys);
        check(8'(running), 8'h01);
        pulse(10'h100);
        @(negedge clk_sys);
        check(8'(running), 8'h00);
        check(weighted_count_taps_oe, 8'h00);
        check(8'(time_base_pulse_out), 8'h01);
        check(weighted_count_taps_out, 8'h00);
    endtask
    task automatic t_mono(input logic [7:0] sel);
        pulse({2'b10, sel});
        n = 5;
        @(negedge clk_sys);
        while (n < 1200 && running === 1'b1) begin
            @(negedge clk_sys);
            n++;
        end
        check(8'(n == PERIOD * sel + 8), 8'h01);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_ctrl();
        for (int k = 0; k < 9; k++) t_mono(k < 8 ? 8'h01 << k : 8'h31);
        print_verdict();
    end
endmodule
`default_nettype wire
